// File: sim/serial_flash_bus_and_write_guard_tb.sv
// Bench for the serial flash target: row table, then hand-written cases.
// Assumes sfg_pkg, sfg_core, the checker and the master model come first.
`timescale 1ns/10ps
module serial_flash_bus_and_write_guard_tb;
  import sfg_pkg::*;
  typedef struct packed {
    logic [1:0] wg;
    logic [7:0] op;
    logic [1:0] nb;
    logic [23:0] d;
    logic [15:0] e;
  } sfg_row_t;
  sfg_row_t rows [13] = '{
    '{2'h1, 8'h06, 2'h0, 24'h0, 16'h0002}, '{2'h1, 8'h04, 2'h0, 24'h0, 16'h0000},
    '{2'h1, 8'h01, 2'h2, 24'h1c0000, 16'h0000}, '{2'h3, 8'h01, 2'h2, 24'h600000, 16'h0060},
    '{2'h3, 8'h20, 2'h3, 24'h0, 16'h0060}, '{2'h3, 8'h52, 2'h3, 24'h0, 16'h0060},
    '{2'h3, 8'hd8, 2'h3, 24'h0, 16'h0060}, '{2'h3, 8'hc7, 2'h0, 24'h0, 16'h0060},
    '{2'h3, 8'h01, 2'h2, 24'h800000, 16'h0080}, '{2'h2, 8'h01, 2'h2, 24'h0, 16'h0082},
    '{2'h3, 8'h01, 2'h2, 24'h0, 16'h0000}, '{2'h3, 8'h01, 2'h2, 24'h000300, 16'h0300},
    '{2'h3, 8'h01, 2'h2, 24'h0, 16'h0302}};
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic sel_n;
  logic sclk;
  logic [3:0] m_lanes;
  logic [3:0] lane_o;
  logic [3:0] lane_oe;
  logic [15:0] status;
  logic busy;
  logic paused;
  logic pd;
  logic lockout;
  logic [7:0] r;
  int error_cnt = 0;
  int checks = 0;
  wire [3:0] lanes = (lane_oe & lane_o) | (~lane_oe & m_lanes);
  always #25 sys_clk = ~sys_clk;
  sfg_mst sfg_mst_i (.clk_i(sys_clk), .so_i(lane_oe[1] ? lane_o[1] : 1'bz),
    .select_n_o(sel_n), .serial_clk_o(sclk), .lanes_o(m_lanes));
  sfg_core #(.LOCKOUT_CYCLES(200)) sfg_core_i (.sys_clk_i(sys_clk), .srst_i(srst),
    .select_n_i(sel_n), .serial_clk_i(sclk), .data_lane_i(lanes), .data_lane_o(lane_o),
    .data_lane_oe_o(lane_oe), .status_o(status), .busy_o(busy), .paused_o(paused),
    .power_down_o(pd), .lockout_o(lockout));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while ((busy | lockout) !== 1'b0 && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 3000) begin
      chk("wait bound", 16'h0, 16'h1);
      print_verdict();
    end
  endtask
  task automatic do_reset();
    srst = 1'b1;
    repeat (16) @(posedge sys_clk);
    #1;
    chk("reset status", 16'h0, status);
    srst = 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op, input int nb, input logic [23:0] d);
    sfg_mst_i.sel();
    sfg_mst_i.shift(op, 8, r);
    for (int i = 0; i < nb; i++) begin
      sfg_mst_i.shift(d[23 - 8 * i -: 8], 8, r);
    end
    sfg_mst_i.desel();
  endtask
  task automatic rdsr(input logic [7:0] e);
    sfg_mst_i.sel();
    sfg_mst_i.shift(OP_RDSR1, 8, r);
    sfg_mst_i.shift(8'h00, 8, r);
    sfg_mst_i.desel();
    chk("serial status", {8'h00, e}, {8'h00, r});
  endtask
  task automatic wide(input logic [7:0] op, input logic [3:0] e);
    cmd(op, 4, 24'h0);
    sfg_mst_i.sel();
    sfg_mst_i.shift(op, 8, r);
    repeat (4) sfg_mst_i.shift(8'h00, 8, r);
    sfg_mst_i.lanes_o[3] = 1'b0;
    sfg_mst_i.shift(8'h00, 8, r);
    chk("lane enables", {12'h0, e}, {12'h0, lane_oe});
    sfg_mst_i.lanes_o[3] = 1'b1;
    sfg_mst_i.desel();
  endtask
  initial begin
    do_reset();
    cmd(OP_WREN, 0, 24'h0);
    chk("lockout", 16'h1, {15'h0, lockout});
    chk("wpl in lockout", 16'h0, status);
    wait_done();
    foreach (rows[i]) begin
      sfg_mst_i.lanes_o[2] = rows[i].wg[0];
      if (rows[i].wg[1]) begin
        cmd(OP_WREN, 0, 24'h0);
      end
      cmd(rows[i].op, int'(rows[i].nb), rows[i].d);
      wait_done();
      chk("status", rows[i].e, status);
    end
    wide(OP_QUAD_O, 4'hf);
    wide(OP_DUAL_O, 4'h3);
    srst = 1'b1;
    cmd(OP_WREN, 0, 24'h0);
    do_reset();
    wait_done();
    wide(OP_QUAD_O, 4'h0);
    cmd(OP_WREN, 0, 24'h0);
    sfg_mst_i.sel();
    sfg_mst_i.shift(OP_RDSR1, 8, r);
    sfg_mst_i.lanes_o[3] = 1'b0;
    sfg_mst_i.tick(6);
    chk("pause pending", 16'h0, {15'h0, paused});
    sfg_mst_i.serial_clk_o = 1'b0;
    sfg_mst_i.tick(6);
    chk("paused", 16'h1, {15'h0, paused});
    chk("paused oe", 16'h0, {12'h0, lane_oe});
    sfg_mst_i.shift(8'hff, 3, r);
    sfg_mst_i.serial_clk_o = 1'b0;
    sfg_mst_i.tick(4);
    sfg_mst_i.lanes_o[3] = 1'b1;
    sfg_mst_i.tick(6);
    chk("resumed", 16'h0, {15'h0, paused});
    sfg_mst_i.shift(8'h00, 8, r);
    sfg_mst_i.desel();
    chk("held status", 16'h0002, {8'h0, r});
    sfg_mst_i.cpol = 1'b1;
    rdsr(8'h02);
    sfg_mst_i.cpol = 1'b0;
    sfg_mst_i.sel();
    sfg_mst_i.shift(8'h00, 4, r);
    sfg_mst_i.desel();
    cmd(OP_WRDI, 0, 24'h0);
    chk("after abort", 16'h0, status);
    cmd(OP_WREN, 0, 24'h0);
    cmd(OP_SE, 3, 24'h0);
    rdsr(8'h03);
    cmd(OP_WRDI, 0, 24'h0);
    chk("busy refuse", 16'h0003, status);
    wait_done();
    chk("after erase", 16'h0, status);
    cmd(OP_PD, 0, 24'h0);
    cmd(OP_WREN, 0, 24'h0);
    chk("power down", 16'h1, {15'h0, pd});
    chk("pd refuse", 16'h0, status);
    cmd(OP_RPD, 0, 24'h0);
    cmd(OP_WREN, 0, 24'h0);
    chk("released", 16'h0002, {status[15:1], pd});
    print_verdict();
  end
endmodule
bind sfg_core sfg_core_monitor sfg_core_monitor_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
  .select_n_i(select_n_i), .data_lane_oe_o(data_lane_oe_o), .status_o(status_o),
  .busy_o(busy_o), .paused_o(paused_o), .power_down_o(power_down_o), .lockout_o(lockout_o));

// File: sim/sfg_core_monitor.sv
// Port checker for the serial flash target core.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/10ps
module sfg_core_monitor (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic select_n_i,
  input wire logic [3:0] data_lane_oe_o,
  input wire logic [15:0] status_o,
  input wire logic busy_o,
  input wire logic paused_o,
  input wire logic power_down_o,
  input wire logic lockout_o
);
  default clocking
    @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  idle_release_a: assert property (select_n_i [*8] |-> data_lane_oe_o == 4'h0)
    else $error("lanes driven while deselected");
  pause_float_a: assert property (paused_o |-> data_lane_oe_o == 4'h0)
    else $error("lanes driven while paused");
  pause_sel_a: assert property ($rose(paused_o) |-> !select_n_i)
    else $error("pause began while deselected");
  busy_start_a: assert property ($rose(busy_o) |-> select_n_i)
    else $error("busy began inside a transfer");
  busy_hold_a: assert property ($rose(busy_o) |=> busy_o [*8])
    else $error("busy ended too soon");
  lockout_wpl_a: assert property (lockout_o |-> !status_o[1])
    else $error("write latch set during lockout");
  done_clears_a: assert property ($fell(busy_o) |-> !status_o[1])
    else $error("write latch kept after completion");
  quad_nopause_a: assert property (status_o[9] |-> !paused_o)
    else $error("pause taken with quad lanes on");
  pd_frozen_a: assert property (power_down_o && $past(power_down_o) |-> $stable(status_o))
    else $error("status changed in power down");
  cover property ($rose(busy_o));
  cover property ($rose(paused_o));
  cover property ($rose(power_down_o));
endmodule

// File: sim/sfg_mst.sv
// Serial bus master model: select, serial clock and lanes 0, 2 and 3.
// Assumes the bench calls its tasks; one bit cell is 8 system clocks.
`timescale 1ns/10ps
module sfg_mst (
  input wire logic clk_i,
  input wire logic so_i,
  output logic select_n_o,
  output logic serial_clk_o,
  output logic [3:0] lanes_o
);
  logic cpol = 1'b0;
  initial begin
    select_n_o = 1'b1;
    serial_clk_o = 1'b0;
    lanes_o = 4'hc;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic sel();
    tick(1);
    serial_clk_o = cpol;
    tick(2);
    select_n_o = 1'b0;
    tick(4);
  endtask
  task automatic desel();
    serial_clk_o = cpol;
    tick(4);
    select_n_o = 1'b1;
    lanes_o[0] = ~lanes_o[0];
    tick(8);
  endtask
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      serial_clk_o = 1'b0;
      lanes_o[0] = tx[i];
      tick(4);
      serial_clk_o = 1'b1;
      tick(4);
      rx[i] = so_i;
    end
  endtask
endmodule

// File: src/sfg_core.sv
// Serial flash bus target and write guard logic.
// Assumes pins arrive asynchronously; power-level reset arrives as srst_i.
`timescale 1ns/10ps
module sfg_core import sfg_pkg::*; #(
  parameter int LOCKOUT_CYCLES = LOCKOUT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic select_n_i,
  input wire logic serial_clk_i,
  input wire logic [3:0] data_lane_i,
  output logic [3:0] data_lane_o,
  output logic [3:0] data_lane_oe_o,
  output logic [15:0] status_o,
  output logic busy_o,
  output logic paused_o,
  output logic power_down_o,
  output logic lockout_o
);
  initial begin
    if (LOCKOUT_CYCLES < 1) $error("LOCKOUT_CYCLES must be at least one");
  end

  typedef enum {ST_OPC, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA, ST_IGNORE} sfg_state_t;

  function automatic logic is_quad(input logic [7:0] op);
    return op == OP_QUAD_O || op == OP_QUAD_IO || op == OP_QUAD_OW;
  endfunction
  function automatic logic is_dual(input logic [7:0] op);
    return op == OP_DUAL_O || op == OP_DUAL_IO;
  endfunction
  function automatic logic is_wr(input logic [7:0] op);
    return op == OP_PP || op == OP_SE || op == OP_BE32 || op == OP_BE64 || op == OP_CE;
  endfunction

  // Two-stage synchronisers on every pin
  logic [6:0] meta, sync;
  always_ff @(posedge sys_clk_i) begin
    meta <= {select_n_i, serial_clk_i, data_lane_i, 1'b0};
    sync <= meta;
  end
  wire cs_n = sync[6];
  wire sck = sync[5];
  wire [3:0] lanes = sync[4:1];

  logic sck_d, cs_d, hold_d;
  always_ff @(posedge sys_clk_i) begin
    sck_d <= sck;
    cs_d <= cs_n;
    hold_d <= lanes[3];
  end
  wire sck_rise = sck & ~sck_d;
  wire sck_fall = ~sck & sck_d;
  wire cs_fall = ~cs_n & cs_d;

  sfg_nv_t nv;
  logic wpl, busy, pd, paused, hold_req, quad_xfer;
  logic [31:0] lock_cnt, busy_cnt;
  sfg_state_t state;
  logic [7:0] opcode, shreg, wbyte0, wbyte1;
  logic [5:0] bitcnt;
  logic [1:0] wcount;
  logic [1:0] pend;
  logic [3:0] out_q;
  logic [3:0] oe_q;

  wire lockout = lock_cnt != 32'h0;
  wire sel = ~cs_n;
  wire hold_on = ~nv.quad_lane_enable & ~quad_xfer;
  wire pause_fall = sel & hold_on & ~lanes[3] & hold_d;
  wire pause_rise = lanes[3] & ~hold_d;
  wire pins_ok = (sel & ~paused) & ~srst_i;
  wire [1:0] width = quad_xfer ? 2'd2 : (is_dual(opcode) && state != ST_OPC ? 2'd1 : 2'd0);
  wire [2:0] step = 3'd1 << width;
  wire step_in = pins_ok & sck_rise & ~hold_req;
  wire step_out = pins_ok & sck_fall;
  wire [7:0] shin0 = {shreg[6:0], lanes[0]};
  wire [7:0] shin1 = {shreg[5:0], lanes[1], lanes[0]};
  wire [7:0] shin2 = {shreg[3:0], lanes[3:0]};
  wire [7:0] shin = width == 2'd2 ? shin2 : (width == 2'd1 ? shin1 : shin0);
  wire byte_done = step_in && (bitcnt + 6'(step)) >= 6'd8;
  wire [7:0] nop = shin;
  wire [15:0] status_full = {6'h00, nv.quad_lane_enable, nv.status_lock_mode_1,
                             nv.status_lock_mode_0, nv.small_unit_select,
                             nv.protect_low_end, nv.protect_size, wpl, busy};
  wire sfg_lock_t lockm = sfg_lock_t'({nv.status_lock_mode_1, nv.status_lock_mode_0});
  wire guard_pin = nv.quad_lane_enable ? 1'b1 : lanes[2];
  wire wrsr_ok = wpl && !lockout && (lockm == SFG_LOCK_SW ||
                 (lockm == SFG_LOCK_PIN && guard_pin));
  // Opcode acceptance at the byte boundary
  wire acc_any = !busy && !pd;
  wire acc_wren = acc_any && !lockout;
  wire acc_write = acc_wren && wpl;

  // Power-up lockout counter
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) lock_cnt <= LOCKOUT_CYCLES;
    else if (lockout) lock_cnt <= lock_cnt - 32'h1;
  end

  // Pause entry and exit follow the clock level
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || cs_n) begin
      paused <= 1'b0;
      pend <= 2'b00;
    end else if (!hold_on && !paused) begin
      pend <= 2'b00;
    end else if (pause_fall) begin
      if (!sck) paused <= 1'b1;
      else pend <= 2'b01;
    end else if (pause_rise && paused) begin
      if (!sck) paused <= 1'b0;
      else pend <= 2'b10;
    end else if (sck_fall && pend != 2'b00) begin
      paused <= pend == 2'b01;
      pend <= 2'b00;
    end
  end
  assign hold_req = pend == 2'b01;

  // Serial engine
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= ST_OPC;
      bitcnt <= 6'd0;
      opcode <= 8'h00;
      shreg <= 8'h00;
      quad_xfer <= 1'b0;
      wcount <= 2'd0;
      wbyte0 <= 8'h00;
      wbyte1 <= 8'h00;
      wpl <= 1'b0;
      pd <= 1'b0;
      busy <= 1'b0;
      busy_cnt <= 32'h0;
      nv <= sfg_nv_t'(STATUS_RESET[9:2]);
    end else begin
      if (busy) begin
        if (busy_cnt == 32'h0) begin
          // Latch drops with the busy flag, on completion
          busy <= 1'b0;
          wpl <= 1'b0;
        end else begin
          busy_cnt <= busy_cnt - 32'h1;
        end
      end
      if (cs_n) begin
        // Select high ends the transfer and commits a status write
        if (!cs_d && state == ST_WDATA && opcode == OP_WRSR && wcount != 2'd0 && wrsr_ok) begin
          nv.protect_size <= wbyte0[4:2];
          nv.protect_low_end <= wbyte0[5];
          nv.small_unit_select <= wbyte0[6];
          nv.status_lock_mode_0 <= wbyte0[7];
          if (wcount == 2'd2) begin
            nv.status_lock_mode_1 <= wbyte1[0];
            nv.quad_lane_enable <= wbyte1[1];
          end
          busy <= 1'b1;
          busy_cnt <= WRSR_CYC;
        end else if (!cs_d && state == ST_WDATA && is_wr(opcode)) begin
          // Program and erase start only once select has risen
          busy <= 1'b1;
          busy_cnt <= PROG_CYC;
        end
        state <= ST_OPC;
        bitcnt <= 6'd0;
        quad_xfer <= 1'b0;
        wcount <= 2'd0;
      end else if (cs_fall) begin
        state <= ST_OPC;
        bitcnt <= 6'd0;
      end else if (step_in && state != ST_IGNORE) begin
        shreg <= shin;
        bitcnt <= byte_done ? 6'd0 : bitcnt + 6'(step);
        if (byte_done) begin
          case (state)
            ST_OPC: begin
              opcode <= nop;
              state <= ST_IGNORE;
              if (pd) begin
                if (nop == OP_RPD) pd <= 1'b0;
              end else if (busy) begin
                if (nop == OP_RDSR1 || nop == OP_RDSR2) state <= ST_RDATA;
              end else begin
                case (nop)
                  OP_WREN: if (acc_wren) wpl <= 1'b1;
                  OP_WRDI: wpl <= 1'b0;
                  OP_PD: pd <= 1'b1;
                  OP_RDSR1, OP_RDSR2: state <= ST_RDATA;
                  OP_WRSR: if (acc_write) state <= ST_WDATA;
                  default: begin
                    if (is_wr(nop) && acc_write) begin
                      // Array engine absent: collect address and data, then model busy
                      state <= ST_WDATA;
                    end else if (is_quad(nop) && nv.quad_lane_enable) begin
                      quad_xfer <= 1'b1;
                      state <= ST_ADDR;
                    end else if (is_dual(nop)) begin
                      state <= ST_ADDR;
                    end
                  end
                endcase
              end
            end
            ST_ADDR: begin
              wcount <= wcount + 2'd1;
              if (wcount == 2'd2) state <= ST_RDATA;
            end
            ST_WDATA: begin
              if (wcount == 2'd0) wbyte0 <= nop;
              if (wcount == 2'd1) wbyte1 <= nop;
              if (wcount != 2'd2) wcount <= wcount + 2'd1;
            end
            default: state <= state;
          endcase
        end
      end
    end
  end
  wire _unused = acc_any & quad_xfer;

  // Output shifter: status read repeats, fast reads return zero data
  logic [2:0] obit;
  wire [7:0] out_byte = opcode == OP_RDSR2 ? status_full[15:8] : status_full[7:0];
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || cs_n || state != ST_RDATA) begin
      out_q <= 4'h0;
      oe_q <= 4'h0;
      obit <= 3'd7;
    end else if (step_out) begin
      oe_q <= quad_xfer ? 4'hf : (is_dual(opcode) ? 4'h3 : 4'h2);
      if (is_dual(opcode) || quad_xfer) begin
        out_q <= 4'h0;
      end else begin
        out_q <= {2'b00, out_byte[obit], 1'b0};
        obit <= obit - 3'd1;
      end
    end
  end

  assign data_lane_o = out_q;
  assign data_lane_oe_o = (paused | cs_n) ? 4'h0 : oe_q;
  assign status_o = status_full;
  assign busy_o = busy;
  assign paused_o = paused;
  assign power_down_o = pd;
  assign lockout_o = lockout;
endmodule

// File: src/sfg_pkg.sv
// Package of constants and carrier types for the serial flash bus and write guard block.
// Assumes one 20 MHz system clock; the serial link clock is sampled as data.
package sfg_pkg;
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int LOCKOUT_US = 1000;
  localparam int LOCKOUT_CYC = LOCKOUT_US * (SYS_CLK_HZ / 1_000_000);
  localparam int WRSR_US = 10;
  localparam int PROG_US = 100;
  localparam int WRSR_CYC = WRSR_US * (SYS_CLK_HZ / 1_000_000);
  localparam int PROG_CYC = PROG_US * (SYS_CLK_HZ / 1_000_000);
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hd8;
  localparam logic [7:0] OP_CE = 8'hc7;
  localparam logic [7:0] OP_PD = 8'hb9;
  localparam logic [7:0] OP_RPD = 8'hab;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_DUAL_O = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_O = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_QUAD_OW = 8'he3;
  localparam int BIT_BUSY = 0;
  localparam int BIT_WPL = 1;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  typedef enum logic [1:0] {SFG_LOCK_SW, SFG_LOCK_PIN, SFG_LOCK_PWR, SFG_LOCK_OTP} sfg_lock_t;
  typedef struct packed {
    logic quad_lane_enable;
    logic status_lock_mode_1;
    logic status_lock_mode_0;
    logic small_unit_select;
    logic protect_low_end;
    logic [2:0] protect_size;
  } sfg_nv_t;
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } sfg_lanes_t;
endpackage
